// File: src/ssu_pkg.sv
// constants and types for the step sequencer unit
package ssu_pkg;
	localparam int CLK_HZ = 250000000;
	localparam real TICK_S = 0.1;
	localparam int TICK_CYC = int'(TICK_S * CLK_HZ);
	localparam int SCAN_HZ = 1000;
	localparam int SCAN_CYC = CLK_HZ / SCAN_HZ;
	localparam int STEP_MAX = 100;
	localparam int STEP_W = 7;
	localparam int CNT_W = 16;
	localparam int INST_BASE = 901;
	localparam int INST_LAST = 932;
	localparam int CYCLE_OFS = 50;
	localparam int NFAULT = 11;
	localparam logic [7:0] FAULT_LIST [NFAULT] = '{8'h01, 8'h02, 8'h03,
		8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h1A, 8'h33};
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_MASK = 32'h0000_0004;
	localparam logic [31:0] ADDR_LAST = 32'h0000_0008;
	localparam logic [31:0] ADDR_RSTEP = 32'h0000_000C;
	localparam logic [31:0] ADDR_STAT = 32'h0000_0010;
	localparam logic [31:0] ADDR_ACC = 32'h0000_0014;
	localparam logic [31:0] ADDR_INST = 32'h0000_0018;
	localparam logic [31:0] ADDR_PAT = 32'h0000_0400;
	localparam logic [31:0] ADDR_PRE = 32'h0000_0800;
	localparam logic [31:0] ADDR_PROT = 32'h0000_0C00;
	localparam logic [31:0] PAGE_MASK = 32'hFFFF_FC00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [9:0] INST_RST = 10'h385;
	typedef enum {SSU_IDLE, SSU_RUN} ssu_run_t;
endpackage

// File: src/step_sequencer_unit.sv
// step sequencer core with axi4-lite register slave
`timescale 1ns/10ps
module ssu_step_sequencer_unit (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic RUNG_IN,
	input wire logic SEQ_RESET_IN,
	input wire logic RUN_MODE,
	input wire logic FAULT_VALID,
	input wire logic [7:0] FAULT_CODE,
	input wire logic [7:0] EXT_INPUTS,
	input wire logic [7:0] INT_BITS,
	input wire logic [7:0] OTHER_OUT,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [7:0] GROUP_OUT,
	output logic [9:0] STEP_DONE_ADDR,
	output logic [9:0] CYCLE_DONE_ADDR,
	output logic STEP_DONE,
	output logic CYCLE_DONE,
	output logic MATCH,
	output logic [ssu_pkg::STEP_W-1:0] CUR_STEP
);
	import ssu_pkg::*;

	// rung, sequencer reset, run mode and external input pins pass a two-stage synchroniser; fault inputs do not
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [7:0] ext1_reg;
	logic [7:0] ext2_reg;
	always_ff @(posedge REF_CLK) begin
		s1_reg <= {RUNG_IN, SEQ_RESET_IN, RUN_MODE};
		s2_reg <= s1_reg;
		ext1_reg <= EXT_INPUTS;
		ext2_reg <= ext1_reg;
	end
	logic rung_s;
	logic sreset_s;
	assign rung_s = s2_reg[2];
	assign sreset_s = s2_reg[1];

	// configuration registers
	logic event_mode_reg;
	logic match_form_reg;
	logic src_int_reg;
	logic [7:0] mask_reg;
	logic [STEP_W-1:0] last_step_reg;
	logic [STEP_W-1:0] rstep_reg;
	logic [9:0] inst_reg;
	logic [7:0] pat_mem [STEP_MAX];
	logic [CNT_W-1:0] pre_mem [STEP_MAX];
	logic [STEP_MAX-1:0] prot_reg;

	// dividers for tick and scan
	logic [27:0] tick_cnt_reg;
	logic [17:0] scan_cnt_reg;
	logic tick_reg;
	logic scan_reg;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 28'(TICK_CYC - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 28'h1;
			tick_reg <= 1'b0;
		end
	end
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			scan_cnt_reg <= '0;
			scan_reg <= 1'b0;
		end else if (scan_cnt_reg == 18'(SCAN_CYC - 1)) begin
			scan_cnt_reg <= '0;
			scan_reg <= 1'b1;
		end else begin
			scan_cnt_reg <= scan_cnt_reg + 18'h1;
			scan_reg <= 1'b0;
		end
	end

	// rung sampled per scan; edge counts only on scan boundaries
	logic rung_scan_reg;
	logic rung_prev_reg;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rung_scan_reg <= 1'b0;
			rung_prev_reg <= 1'b0;
		end else if (scan_reg) begin
			rung_scan_reg <= rung_s;
			rung_prev_reg <= rung_scan_reg;
		end
	end
	logic rise;
	assign rise = scan_reg && rung_scan_reg && !rung_prev_reg;

	logic fault_hit;
	always_comb begin
		fault_hit = 1'b0;
		for (int i = 0; i < NFAULT; i++) begin
			if (FAULT_VALID && FAULT_CODE == FAULT_LIST[i]) begin
				fault_hit = 1'b1;
			end
		end
	end

	// sequencing core; state is kept regardless of run mode
	logic [STEP_W-1:0] step_reg;
	logic [CNT_W-1:0] acc_reg;
	logic step_done_reg;
	logic cycle_done_reg;
	logic done_pend_reg;
	logic count_ev;
	logic reach;
	assign count_ev = event_mode_reg ? rise
		: (tick_reg && rung_scan_reg);
	assign reach = (acc_reg + CNT_W'(1)) >= pre_mem[step_reg];
	always_ff @(posedge REF_CLK) begin
		if (RESET || fault_hit) begin
			step_reg <= '0;
			acc_reg <= '0;
			cycle_done_reg <= 1'b0;
			done_pend_reg <= 1'b0;
		end else if (sreset_s) begin
			step_reg <= rstep_reg;
			acc_reg <= '0;
			cycle_done_reg <= 1'b0;
			done_pend_reg <= 1'b0;
		end else begin
			if (scan_reg) begin
				done_pend_reg <= 1'b0;
			end
			if (count_ev) begin
				if (reach) begin
					acc_reg <= '0;
					done_pend_reg <= 1'b1;
					if (step_reg >= last_step_reg) begin
						step_reg <= '0;
						cycle_done_reg <= 1'b1;
					end else begin
						step_reg <= step_reg + STEP_W'(1);
					end
				end else begin
					acc_reg <= acc_reg + CNT_W'(1);
				end
			end
		end
	end

	// completion flag stands for exactly the next whole scan
	always_ff @(posedge REF_CLK) begin
		if (RESET || fault_hit) begin
			step_done_reg <= 1'b0;
		end else if (scan_reg) begin
			step_done_reg <= done_pend_reg && !match_form_reg;
		end
	end

	// outputs
	logic [7:0] cur_pat;
	logic [7:0] grp;
	assign cur_pat = pat_mem[step_reg] & mask_reg;
	assign grp = src_int_reg ? INT_BITS : ext2_reg;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			GROUP_OUT <= '0;
			MATCH <= 1'b0;
			STEP_DONE <= 1'b0;
			CYCLE_DONE <= 1'b0;
			CUR_STEP <= '0;
			STEP_DONE_ADDR <= INST_RST;
			CYCLE_DONE_ADDR <= INST_RST + 10'(CYCLE_OFS);
		end else begin
			GROUP_OUT <= (OTHER_OUT & ~mask_reg) | cur_pat;
			MATCH <= match_form_reg
				&& ((grp & mask_reg) == cur_pat);
			STEP_DONE <= step_done_reg;
			CYCLE_DONE <= cycle_done_reg && !match_form_reg;
			CUR_STEP <= step_reg;
			STEP_DONE_ADDR <= inst_reg;
			CYCLE_DONE_ADDR <= inst_reg + 10'(CYCLE_OFS);
		end
	end

	// axi4-lite write: address and data taken in either order
	logic aw_have_reg;
	logic w_have_reg;
	logic [31:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wr_go;
	logic wr_ok;
	logic [31:0] widx;
	assign wr_go = aw_have_reg && w_have_reg && !S_AXI_BVALID;
	assign widx = (awaddr_reg & ~PAGE_MASK) >> 2;
	always_comb begin
		wr_ok = 1'b1;
		case (awaddr_reg & PAGE_MASK)
			ADDR_PAT: wr_ok = widx < 32'(STEP_MAX);
			ADDR_PRE: wr_ok = widx < 32'(STEP_MAX)
				&& !prot_reg[widx[6:0]];
			ADDR_PROT: wr_ok = widx < 32'(STEP_MAX);
			32'h0: wr_ok = awaddr_reg <= ADDR_INST;
			default: wr_ok = 1'b0;
		endcase
	end
	assign S_AXI_AWREADY = !aw_have_reg;
	assign S_AXI_WREADY = !w_have_reg;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && !aw_have_reg) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_have_reg) begin
				w_have_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// register stores; only the low byte lane matters for most fields
	logic [6:0] wi;
	logic [31:0] wd;
	assign wi = widx[6:0];
	assign wd = wdata_reg;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			event_mode_reg <= 1'b0;
			match_form_reg <= 1'b0;
			src_int_reg <= 1'b0;
			mask_reg <= MASK_RST;
			last_step_reg <= '0;
			rstep_reg <= '0;
			inst_reg <= INST_RST;
			prot_reg <= '0;
		end else if (wr_go && wr_ok) begin
			case (awaddr_reg & PAGE_MASK)
				ADDR_PROT: prot_reg[wi] <= wd[0];
				32'h0: begin
					case (awaddr_reg)
						ADDR_CTRL: begin
							event_mode_reg <= wd[0];
							match_form_reg <= wd[1];
							src_int_reg <= wd[2];
						end
						ADDR_MASK: mask_reg <= wd[7:0];
						ADDR_LAST: if (wd[6:0] < 7'(STEP_MAX)) begin
							last_step_reg <= wd[6:0];
						end
						ADDR_RSTEP: if (wd[6:0] < 7'(STEP_MAX)) begin
							rstep_reg <= wd[6:0];
						end
						ADDR_INST: if (wd[9:0] >= 10'(INST_BASE)
							&& wd[9:0] <= 10'(INST_LAST)) begin
							inst_reg <= wd[9:0];
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end
	// step tables have no reset: a reset here must not wipe the program
	always_ff @(posedge REF_CLK) begin
		if (wr_go && wr_ok && (awaddr_reg & PAGE_MASK) == ADDR_PAT) begin
			pat_mem[wi] <= wd[7:0];
		end
		if (wr_go && wr_ok && (awaddr_reg & PAGE_MASK) == ADDR_PRE) begin
			pre_mem[wi] <= wd[CNT_W-1:0];
		end
	end

	// axi4-lite read
	logic [31:0] rd_val;
	logic rd_ok;
	logic [31:0] ridx;
	assign ridx = (S_AXI_ARADDR & ~PAGE_MASK) >> 2;
	always_comb begin
		rd_val = '0;
		rd_ok = 1'b1;
		case (S_AXI_ARADDR & PAGE_MASK)
			ADDR_PAT: begin
				rd_ok = ridx < 32'(STEP_MAX);
				if (rd_ok) begin
					rd_val = {24'h0, pat_mem[ridx[6:0]] & mask_reg};
				end
			end
			ADDR_PRE: begin
				rd_ok = ridx < 32'(STEP_MAX);
				if (rd_ok) begin
					rd_val = {16'h0, pre_mem[ridx[6:0]]};
				end
			end
			ADDR_PROT: begin
				rd_ok = ridx < 32'(STEP_MAX);
				if (rd_ok) begin
					rd_val = {31'h0, prot_reg[ridx[6:0]]};
				end
			end
			32'h0: begin
				case (S_AXI_ARADDR)
					ADDR_CTRL: rd_val = {29'h0, src_int_reg,
						match_form_reg, event_mode_reg};
					ADDR_MASK: rd_val = {24'h0, mask_reg};
					ADDR_LAST: rd_val = {25'h0, last_step_reg};
					ADDR_RSTEP: rd_val = {25'h0, rstep_reg};
					ADDR_STAT: rd_val = {20'h0, MATCH, CYCLE_DONE,
						STEP_DONE, sreset_s, 1'b0, step_reg};
					ADDR_ACC: rd_val = {16'h0, acc_reg};
					ADDR_INST: rd_val = {22'h0, inst_reg};
					default: rd_ok = 1'b0;
				endcase
			end
			default: rd_ok = 1'b0;
		endcase
	end
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_val;
			S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule

// File: verification/ssu_ladder_model.sv
// ladder-side model: rung and sequencer reset lines
`timescale 1ns/10ps
module ssu_ladder_model (
	input wire logic clk,
	input wire logic rung_cmd,
	input wire logic hold_cmd,
	output logic rung = 1'h0,
	output logic seq_reset = 1'h0
);
	// ladder logic only moves its lines once an edge has passed
	always @(posedge clk) rung <= rung_cmd;
	always @(posedge clk) seq_reset <= hold_cmd;
endmodule

// File: verification/ssu_step_sequencer_unit_asserts.sv
// port-level assertions for the step sequencer unit
`timescale 1ns/10ps
module ssu_step_sequencer_unit_asserts (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic SEQ_RESET_IN,
	input wire logic FAULT_VALID,
	input wire logic [7:0] FAULT_CODE,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic [9:0] STEP_DONE_ADDR,
	input wire logic [9:0] CYCLE_DONE_ADDR,
	input wire logic STEP_DONE,
	input wire logic CYCLE_DONE,
	input wire logic [ssu_pkg::STEP_W-1:0] CUR_STEP
);
	import ssu_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	addr_pair_a: assert property (
		CYCLE_DONE_ADDR == STEP_DONE_ADDR + CYCLE_OFS)
		else $error("cycle flag address off");
	inst_range_a: assert property (
		STEP_DONE_ADDR inside {[INST_BASE:INST_LAST]})
		else $error("instance address out of range");
	step_max_a: assert property (CUR_STEP < STEP_MAX)
		else $error("step beyond maximum");
	cycle_hold_a: assert property (SEQ_RESET_IN [*6] |-> !CYCLE_DONE)
		else $error("cycle flag kept under reset input");
	// seven cycles covers the input synchroniser plus the load
	rst_hold_a: assert property (
		(SEQ_RESET_IN && !FAULT_VALID) [*7] |-> $stable(CUR_STEP))
		else $error("step moved under reset input");
	fault_clr_a: assert property (
		FAULT_VALID && !SEQ_RESET_IN &&
		FAULT_CODE inside {[8'h01:8'h09], 8'h1A, 8'h33} |->
		##2 (CUR_STEP == 0 && !CYCLE_DONE && !STEP_DONE))
		else $error("fault did not clear state");
	// both halves held and no answer pending: answer on the next edge
	wr_busy_a: assert property (
		!S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID |=> S_AXI_BVALID)
		else $error("write answer late");
	rd_answer_a: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	cover property (FAULT_VALID);
	cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
	cover property (SEQ_RESET_IN [*6]);
endmodule
bind ssu_step_sequencer_unit ssu_step_sequencer_unit_asserts u_chk (
	.REF_CLK(REF_CLK), .RESET(RESET), .SEQ_RESET_IN(SEQ_RESET_IN),
	.FAULT_VALID(FAULT_VALID), .FAULT_CODE(FAULT_CODE),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .STEP_DONE_ADDR(STEP_DONE_ADDR),
	.CYCLE_DONE_ADDR(CYCLE_DONE_ADDR), .STEP_DONE(STEP_DONE),
	.CYCLE_DONE(CYCLE_DONE), .CUR_STEP(CUR_STEP));

// File: verification/tb_step_sequencer_unit.sv
// self-checking bench for the step sequencer unit
`timescale 1ns/10ps
module tb_step_sequencer_unit;
	import ssu_pkg::*;
	logic clk = 0, rst = 1, fv = 0, rc = 0, hc = 0, rm = 1, mt;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0] fc = 0, ext = 0, ib = 0, oth = 0, m, p, o, i, g;
	logic [31:0] awa = 0, wd = 0, ara = 0, rd;
	logic [1:0] resp;
	// mask, pattern, other logic, group, expected output, expected match
	logic [40:0] rows [5] = '{{8'hFF, 8'h3C, 8'h00, 8'h3C, 8'h3C, 1'h1},
		{8'h4F, 8'h48, 8'hB0, 8'h49, 8'hF8, 1'h0},
		{8'h00, 8'hFF, 8'hA5, 8'h12, 8'hA5, 1'h1},
		{8'hF0, 8'hA5, 8'h0F, 8'hAF, 8'hAF, 1'h1},
		{8'h4F, 8'h4B, 8'h00, 8'h0B, 8'h4B, 1'h0}};
	wire awr, wr, bv, arr, rv, rg, sri, sd, cd, md;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [7:0] go;
	wire [9:0] sa, ca;
	wire [STEP_W-1:0] cs;
	int miscompares = 0, n_tests = 0;
	ssu_step_sequencer_unit dut (.REF_CLK(clk), .RESET(rst), .RUNG_IN(rg),
		.SEQ_RESET_IN(sri), .RUN_MODE(rm), .FAULT_VALID(fv), .FAULT_CODE(fc),
		.EXT_INPUTS(ext), .INT_BITS(ib), .OTHER_OUT(oth),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .GROUP_OUT(go),
		.STEP_DONE_ADDR(sa), .CYCLE_DONE_ADDR(ca), .STEP_DONE(sd),
		.CYCLE_DONE(cd), .MATCH(md), .CUR_STEP(cs));
	ssu_ladder_model lad (.clk(clk), .rung_cmd(rc), .hold_cmd(hc),
		.rung(rg), .seq_reset(sri));
	initial forever #2 clk = ~clk;
	task automatic results;
		$display("checks %0d errors %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic axi(logic w, logic [31:0] a, logic [31:0] d);
		int t;
		logic aw_hs;
		logic w_hs;
		logic ar_hs;
		logic dn;
		t = 0;
		dn = 0;
		@(posedge clk);
		awa <= a;
		ara <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		bre <= w;
		arv <= !w;
		rre <= !w;
		// handshakes are judged on settled values before the edge
		do begin
			@(negedge clk);
			aw_hs = awv && awr;
			w_hs = wv && wr;
			ar_hs = arv && arr;
			dn = (bre && bv) || (rre && rv);
			if (dn) begin
				resp = bre ? br : rr;
				rd = rdat;
			end
			@(posedge clk);
			t++;
			if (aw_hs) awv <= 0;
			if (w_hs) wv <= 0;
			if (ar_hs) arv <= 0;
			if (dn) begin
				bre <= 0;
				rre <= 0;
			end
		end while (t < 50 && !dn);
		if (!dn) begin
			miscompares++;
			results();
		end
	endtask
	function automatic logic [31:0] sel(int k);
		return k == 0 ? go : k == 1 ? md : k == 2 ? cs : k == 3 ? sa : ca;
	endfunction
	// outputs trail the register write by a few cycles; bounded wait
	task automatic see(string nm, int k, logic [31:0] e);
		int t;
		for (t = 0; t < 40 && sel(k) !== e; t++) @(posedge clk);
		chk(nm, e, sel(k));
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		axi(0, ADDR_MASK, 0);
		chk("mask", MASK_RST, rd);
		axi(0, ADDR_INST, 0);
		chk("inst", INST_BASE, rd);
		see("cyc_addr", 4, INST_BASE + CYCLE_OFS);
		axi(0, 32'h100, 0);
		chk("bad_resp", RESP_SLVERR, resp);
		foreach (rows[n]) begin
			{m, p, o, i, g, mt} = rows[n];
			axi(1, ADDR_MASK, m);
			axi(1, ADDR_PAT, p);
			oth <= o;
			ext <= i;
			ib <= ~i;
			axi(1, ADDR_CTRL, 32'h0);
			see("group", 0, g);
			axi(1, ADDR_CTRL, 32'h2);
			see("match_ext", 1, mt);
			ib <= i;
			ext <= ~i;
			axi(1, ADDR_CTRL, 32'h6);
			see("match_int", 1, mt);
		end
		axi(1, ADDR_INST, INST_LAST);
		see("cyc_last", 4, INST_LAST + CYCLE_OFS);
		axi(1, ADDR_PROT, 32'h1);
		axi(1, ADDR_PRE, 32'h7);
		chk("prot_resp", RESP_SLVERR, resp);
		axi(1, ADDR_PROT, 32'h0);
		axi(1, ADDR_PRE, 32'h7);
		axi(0, ADDR_PRE, 0);
		chk("preset", 32'h7, rd);
		axi(1, ADDR_MASK, 32'hFF);
		axi(1, ADDR_CTRL, 32'h0);
		axi(1, ADDR_RSTEP, 32'h5);
		axi(1, ADDR_PAT + 20, 32'h5A);
		oth <= 0;
		rc <= 1;
		foreach (FAULT_LIST[k]) begin
			hc <= 1;
			see("restart", 2, 5);
			see("grp_rst", 0, 8'h5A);
			repeat (8) @(posedge clk);
			hc <= 0;
			repeat (6) @(posedge clk);
			fc <= FAULT_LIST[k];
			fv <= 1;
			see("fault", 2, 0);
			fv <= 0;
		end
		hc <= 1;
		see("restart", 2, 5);
		hc <= 0;
		rm <= 0;
		fc <= 8'h0A;
		fv <= 1;
		repeat (10) @(posedge clk);
		chk("kept", 5, cs);
		results();
	end
	// the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule
